/* File: hw/analog_ctrl_pkg.sv */
// Operation
// - Mode bit one selects diode emulation
// - Drive strength one means 1A, zero 2A
// - Bypass bits remove dead time per edge
// - Sense pull-down and pull-up enables
// - Arm undervoltage and overvoltage accelerators
// - Armed fault forces both gates low
// - Overvoltage comparator off ignores threshold
// - Undervoltage comparator off ignores threshold
// - Measure start reads zero when idle
// - Four block enables switch their circuitry
// - Driver disable resets one, gates low
// - Separate high and low driver disables
// - Bits six and five read zero
// - Bench enable routes buffer to pin
// - Three-bit system role encoding
// - Five-bit buffer source select
`default_nettype none
package analog_ctrl_pkg;
  // ==========================================
  // Register map (word aligned byte addresses)
  localparam logic [3:0] ADDR_PERIPH_EN  = 4'h0;
  localparam logic [3:0] ADDR_BLOCK_EN   = 4'h4;
  localparam logic [3:0] ADDR_BENCH_TEST = 4'h8;
  localparam logic [3:0] ADDR_BUFFER_MUX = 4'hC;
  localparam logic [7:0] RST_PERIPH_EN   = 8'h00;
  localparam logic [7:0] RST_BLOCK_EN    = 8'h00;
  localparam logic [7:0] RST_BENCH_TEST  = 8'h81;
  localparam logic [7:0] RST_BUFFER_MUX  = 8'h00;
  localparam logic [7:0] BENCH_WR_MASK   = 8'h9F;
  // ==========================================
  // Field positions
  localparam int PE_MODE = 7;
  localparam int PE_STR  = 6;
  localparam int PE_HBY  = 5;
  localparam int PE_LBY  = 4;
  localparam int PE_PD   = 3;
  localparam int PE_PU   = 2;
  localparam int PE_UVA  = 1;
  localparam int PE_OVA  = 0;
  localparam int BE_OVC  = 7;
  localparam int BE_UVC  = 6;
  localparam int BE_MEAS = 5;
  localparam int BE_SLP  = 4;
  localparam int BE_CUR  = 3;
  localparam int BE_TMP  = 2;
  localparam int BE_EFF  = 1;
  localparam int BE_PATH = 0;
  localparam int BT_HID  = 3;
  localparam int BT_LOD  = 2;
  localparam int BT_BNCH = 1;
  localparam int BT_DRV  = 0;
  localparam int BM_ROLE = 5;
  // ==========================================
  // System roles
  localparam logic [2:0] ROLE_STANDALONE = 3'h0;
  localparam logic [2:0] ROLE_MO_MASTER  = 3'h1;
  localparam logic [2:0] ROLE_MO_SLAVE   = 3'h2;
  localparam logic [2:0] ROLE_MP_MASTER  = 3'h3;
  localparam logic [2:0] ROLE_MP_SLAVE   = 3'h4;
  // Buffer source examples
  localparam logic [4:0] SRC_INDUCTOR    = 5'h00;
  localparam logic [4:0] SRC_BANDGAP     = 5'h03;
  localparam logic [4:0] SRC_OVERCURRENT = 5'h1D;
endpackage
`default_nettype wire

/* File: hw/gate_fault_guard.sv */
`timescale 1ns/1ns
`default_nettype none
module gate_fault_guard (
  input  wire logic clk_i,          // Core clock
  input  wire logic rst_i,          // Sync reset
  input  wire logic high_req_i,     // Raw high-side drive
  input  wire logic low_req_i,      // Raw low-side drive
  input  wire logic uv_fault_i,     // Undervoltage detected
  input  wire logic ov_fault_i,     // Overvoltage detected
  input  wire logic uv_cmp_en_i,    // UV comparator enabled
  input  wire logic ov_cmp_en_i,    // OV comparator enabled
  input  wire logic uv_arm_i,       // UV accelerator armed
  input  wire logic ov_arm_i,       // OV accelerator armed
  input  wire logic all_dis_i,      // Both drivers disabled
  input  wire logic high_dis_i,     // High driver disabled
  input  wire logic low_dis_i,      // Low driver disabled
  output logic      high_gate_o,    // Gated high drive
  output logic      low_gate_o,     // Gated low drive
  output logic      fault_kill_o    // Accelerator tripped
);
  logic uv_hit;
  logic ov_hit;
  logic kill;
  // Disabled comparator contributes nothing
  assign uv_hit = uv_cmp_en_i & uv_fault_i & uv_arm_i;
  assign ov_hit = ov_cmp_en_i & ov_fault_i & ov_arm_i;
  assign kill   = uv_hit | ov_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_gate_o  <= 1'b0;
      low_gate_o   <= 1'b0;
      fault_kill_o <= 1'b0;
    end else begin
      high_gate_o  <= high_req_i & ~kill & ~all_dis_i & ~high_dis_i;
      low_gate_o   <= low_req_i & ~kill & ~all_dis_i & ~low_dis_i;
      fault_kill_o <= kill;
    end
  end
endmodule
`default_nettype wire

/* File: hw/analog_block_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module analog_block_control_regs (
  input  wire logic        clk_i,                    // 25 MHz core clock
  input  wire logic        rst_i,                    // Sync reset, high
  input  wire logic        cyc_i,                    // Wishbone cycle
  input  wire logic        stb_i,                    // Wishbone strobe
  input  wire logic        we_i,                     // Write enable
  input  wire logic [3:0]  adr_i,                    // Byte address
  input  wire logic [3:0]  sel_i,                    // Byte selects
  input  wire logic [31:0] dat_i,                    // Write data
  output logic [31:0]      dat_o,                    // Read data
  output logic             ack_o,                    // Acknowledge
  input  wire logic        measure_done_i,           // Measurement finished pulse
  input  wire logic        high_drive_req_i,         // PWM high request
  input  wire logic        low_drive_req_i,          // PWM low request
  input  wire logic        undervolt_fault_i,        // UV comparator result
  input  wire logic        overvolt_fault_i,         // OV comparator result
  input  wire logic        debug_pin_normal_i,       // Pin normal function
  input  wire logic        buffer_out_i,             // Buffer output level
  output logic             high_gate_drive_o,        // High-side gate
  output logic             low_gate_drive_o,         // Low-side gate
  output logic             fault_kill_o,             // Accelerator tripped
  output logic             analog_debug_pin_o,       // Debug pin level
  output logic             rectification_mode_sel_o, // 1 diode emulation
  output logic             high_drive_strength_sel_o,// 1 = 1A, 0 = 2A
  output logic             high_dead_time_bypass_o,  // Skip high dead time
  output logic             low_dead_time_bypass_o,   // Skip low dead time
  output logic             neg_sense_pulldown_en_o,  // Neg sense pull-down
  output logic             pos_sense_pullup_en_o,    // Pos sense pull-up
  output logic             undervolt_accel_en_o,     // UV accelerator armed
  output logic             overvolt_accel_en_o,      // OV accelerator armed
  output logic             overvolt_comparator_en_o, // OV comparator on
  output logic             undervolt_comparator_en_o,// UV comparator on
  output logic             efficiency_measure_start_o,// Measurement running
  output logic             slope_comp_bypass_o,      // Slope comp off
  output logic             current_measure_en_o,     // Current sense on
  output logic             temp_sensor_en_o,         // Temp sensor on
  output logic             efficiency_circuit_en_o,  // Efficiency circuit on
  output logic             signal_chain_en_o,        // Voltage path on
  output logic             gate_drivers_disable_o,   // Both drivers off
  output logic             high_driver_disable_o,    // High driver off
  output logic             low_driver_disable_o,     // Low driver off
  output logic             bench_test_en_o,          // Bench mode
  output logic [2:0]       system_role_sel_o,        // System role
  output logic [4:0]       buffer_source_sel_o       // Buffer source
);
  // ==========================================
  // Bus slave
  logic [7:0] analog_peripheral_enable;
  logic [7:0] analog_block_enable;
  logic [7:0] bench_test_control;
  logic [7:0] buffer_mux_control;
  logic       req;
  logic       wr;
  logic       lane0;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign req   = cyc_i & stb_i & ~ack_o;
  assign wr    = req & we_i & sel_i[0];
  assign lane0 = sel_i[0];
  assign wbyte = dat_i[7:0];

  // One wait state: ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_peripheral_enable <= analog_ctrl_pkg::RST_PERIPH_EN;
    end else if (wr && adr_i == analog_ctrl_pkg::ADDR_PERIPH_EN) begin
      analog_peripheral_enable <= wbyte;
    end
  end

  // Measure start: set by write, cleared when measurement ends; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_block_enable <= analog_ctrl_pkg::RST_BLOCK_EN;
    end else if (wr && adr_i == analog_ctrl_pkg::ADDR_BLOCK_EN) begin
      analog_block_enable <= wbyte;
    end else if (measure_done_i) begin
      analog_block_enable[analog_ctrl_pkg::BE_MEAS] <= 1'b0;
    end
  end

  // Unimplemented bits never store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bench_test_control <= analog_ctrl_pkg::RST_BENCH_TEST;
    end else if (wr && adr_i == analog_ctrl_pkg::ADDR_BENCH_TEST) begin
      bench_test_control <= wbyte & analog_ctrl_pkg::BENCH_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_mux_control <= analog_ctrl_pkg::RST_BUFFER_MUX;
    end else if (wr && adr_i == analog_ctrl_pkg::ADDR_BUFFER_MUX) begin
      buffer_mux_control <= wbyte;
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    rbyte = 8'h00;
    case (adr_i)
      analog_ctrl_pkg::ADDR_PERIPH_EN:  rbyte = analog_peripheral_enable;
      analog_ctrl_pkg::ADDR_BLOCK_EN:   rbyte = analog_block_enable;
      analog_ctrl_pkg::ADDR_BENCH_TEST: rbyte = bench_test_control;
      analog_ctrl_pkg::ADDR_BUFFER_MUX: rbyte = buffer_mux_control;
      default:                          rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (req && !we_i && lane0) begin
      dat_o <= {24'h000000, rbyte};
    end else if (req) begin
      dat_o <= 32'h00000000;
    end
  end

  // ==========================================
  // Static control outputs
  assign rectification_mode_sel_o   = analog_peripheral_enable[analog_ctrl_pkg::PE_MODE];
  assign high_drive_strength_sel_o  = analog_peripheral_enable[analog_ctrl_pkg::PE_STR];
  assign high_dead_time_bypass_o    = analog_peripheral_enable[analog_ctrl_pkg::PE_HBY];
  assign low_dead_time_bypass_o     = analog_peripheral_enable[analog_ctrl_pkg::PE_LBY];
  assign neg_sense_pulldown_en_o    = analog_peripheral_enable[analog_ctrl_pkg::PE_PD];
  assign pos_sense_pullup_en_o      = analog_peripheral_enable[analog_ctrl_pkg::PE_PU];
  assign undervolt_accel_en_o       = analog_peripheral_enable[analog_ctrl_pkg::PE_UVA];
  assign overvolt_accel_en_o        = analog_peripheral_enable[analog_ctrl_pkg::PE_OVA];
  assign overvolt_comparator_en_o   = analog_block_enable[analog_ctrl_pkg::BE_OVC];
  assign undervolt_comparator_en_o  = analog_block_enable[analog_ctrl_pkg::BE_UVC];
  assign efficiency_measure_start_o = analog_block_enable[analog_ctrl_pkg::BE_MEAS];
  // Reset leaves slope comp enabled; software is expected to set the bypass
  assign slope_comp_bypass_o        = analog_block_enable[analog_ctrl_pkg::BE_SLP];
  assign current_measure_en_o       = analog_block_enable[analog_ctrl_pkg::BE_CUR];
  assign temp_sensor_en_o           = analog_block_enable[analog_ctrl_pkg::BE_TMP];
  assign efficiency_circuit_en_o    = analog_block_enable[analog_ctrl_pkg::BE_EFF];
  assign signal_chain_en_o          = analog_block_enable[analog_ctrl_pkg::BE_PATH];
  assign gate_drivers_disable_o     = bench_test_control[analog_ctrl_pkg::BT_DRV];
  assign high_driver_disable_o      = bench_test_control[analog_ctrl_pkg::BT_HID];
  assign low_driver_disable_o       = bench_test_control[analog_ctrl_pkg::BT_LOD];
  assign bench_test_en_o            = bench_test_control[analog_ctrl_pkg::BT_BNCH];
  assign system_role_sel_o          = buffer_mux_control[7:analog_ctrl_pkg::BM_ROLE];
  assign buffer_source_sel_o        = buffer_mux_control[4:0];

  // Offset correction is the measurer's job, not done here
  assign analog_debug_pin_o = bench_test_control[analog_ctrl_pkg::BT_BNCH] ?
                              buffer_out_i : debug_pin_normal_i;

  // ==========================================
  // Gate drive protection
  gate_fault_guard u_guard (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .high_req_i   (high_drive_req_i),
    .low_req_i    (low_drive_req_i),
    .uv_fault_i   (undervolt_fault_i),
    .ov_fault_i   (overvolt_fault_i),
    .uv_cmp_en_i  (analog_block_enable[analog_ctrl_pkg::BE_UVC]),
    .ov_cmp_en_i  (analog_block_enable[analog_ctrl_pkg::BE_OVC]),
    .uv_arm_i     (analog_peripheral_enable[analog_ctrl_pkg::PE_UVA]),
    .ov_arm_i     (analog_peripheral_enable[analog_ctrl_pkg::PE_OVA]),
    .all_dis_i    (bench_test_control[analog_ctrl_pkg::BT_DRV]),
    .high_dis_i   (bench_test_control[analog_ctrl_pkg::BT_HID]),
    .low_dis_i    (bench_test_control[analog_ctrl_pkg::BT_LOD]),
    .high_gate_o  (high_gate_drive_o),
    .low_gate_o   (low_gate_drive_o),
    .fault_kill_o (fault_kill_o)
  );
endmodule
`default_nettype wire

/* File: verification/analog_ctrl_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module regs_monitor (
  input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, measure_done_i,       // Clock, reset, bus
  input wire logic [3:0]  adr_i, sel_i,                                                  // Address, selects
  input wire logic [31:0] dat_i, dat_o,                                                  // Bus data
  input wire logic        undervolt_fault_i, overvolt_fault_i, debug_pin_normal_i,       // Analog side
  input wire logic        buffer_out_i, high_gate_drive_o, low_gate_drive_o, fault_kill_o, // Gate side
  input wire logic        analog_debug_pin_o, rectification_mode_sel_o, undervolt_accel_en_o, // Fields
  input wire logic        overvolt_accel_en_o, overvolt_comparator_en_o, undervolt_comparator_en_o, // Fields
  input wire logic        efficiency_measure_start_o, gate_drivers_disable_o, high_driver_disable_o, // Fields
  input wire logic        low_driver_disable_o, bench_test_en_o                          // Fields
);
  // ==========================================
  // Bus steps
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_mode; cyc_i && stb_i && we_i && sel_i[0] && !ack_o && adr_i == 4'h0 ##1 ack_o; endsequence
  sequence rd_bench; cyc_i && stb_i && !we_i && !ack_o && adr_i == 4'h8 ##1 ack_o; endsequence
  // ==========================================
  // Checks
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse one cycle after request");
  mode_write_a: assert property (wr_mode |-> rectification_mode_sel_o == $past(dat_i[7]))
    else $error("mode output does not follow write");
  bench_read_a: assert property (rd_bench |-> dat_o[6:5] == 2'b00 && dat_o[31:8] == 24'h0)
    else $error("unimplemented bench bits read nonzero");
  drv_off_a: assert property (gate_drivers_disable_o |=> !high_gate_drive_o && !low_gate_drive_o)
    else $error("gate driven while drivers disabled");
  high_off_a: assert property (high_driver_disable_o |=> !high_gate_drive_o)
    else $error("high gate driven while disabled");
  low_off_a: assert property (low_driver_disable_o |=> !low_gate_drive_o)
    else $error("low gate driven while disabled");
  uv_kill_a: assert property (undervolt_fault_i && undervolt_comparator_en_o && undervolt_accel_en_o
    |=> fault_kill_o && !high_gate_drive_o && !low_gate_drive_o) else $error("uv fault not acted on");
  ov_kill_a: assert property (overvolt_fault_i && overvolt_comparator_en_o && overvolt_accel_en_o
    |=> fault_kill_o && !high_gate_drive_o && !low_gate_drive_o) else $error("ov fault not acted on");
  debug_mux_a: assert property (analog_debug_pin_o == (bench_test_en_o ? buffer_out_i : debug_pin_normal_i))
    else $error("debug pin source wrong");
  meas_clear_a: assert property (measure_done_i && !cyc_i |=> !efficiency_measure_start_o)
    else $error("measure start not cleared");
endmodule
bind analog_block_control_regs regs_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .measure_done_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .undervolt_fault_i, .overvolt_fault_i, .debug_pin_normal_i, .buffer_out_i,
  .high_gate_drive_o, .low_gate_drive_o, .fault_kill_o, .analog_debug_pin_o, .rectification_mode_sel_o,
  .undervolt_accel_en_o, .overvolt_accel_en_o, .overvolt_comparator_en_o, .undervolt_comparator_en_o,
  .efficiency_measure_start_o, .gate_drivers_disable_o, .high_driver_disable_o, .low_driver_disable_o,
  .bench_test_en_o);
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, measure_done_i, high_drive_req_i, low_drive_req_i;
  logic undervolt_fault_i, overvolt_fault_i, debug_pin_normal_i, buffer_out_i, high_gate_drive_o;
  logic low_gate_drive_o, fault_kill_o, analog_debug_pin_o, rectification_mode_sel_o, high_drive_strength_sel_o;
  logic high_dead_time_bypass_o, low_dead_time_bypass_o, neg_sense_pulldown_en_o, pos_sense_pullup_en_o;
  logic undervolt_accel_en_o, overvolt_accel_en_o, overvolt_comparator_en_o, undervolt_comparator_en_o;
  logic efficiency_measure_start_o, slope_comp_bypass_o, current_measure_en_o, temp_sensor_en_o;
  logic efficiency_circuit_en_o, signal_chain_en_o, gate_drivers_disable_o, high_driver_disable_o;
  logic low_driver_disable_o, bench_test_en_o;
  logic [2:0]  system_role_sel_o;
  logic [4:0]  buffer_source_sel_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int          err_count, checks;
  wire [7:0] pe = {rectification_mode_sel_o, high_drive_strength_sel_o, high_dead_time_bypass_o,
    low_dead_time_bypass_o, neg_sense_pulldown_en_o, pos_sense_pullup_en_o, undervolt_accel_en_o, overvolt_accel_en_o};
  wire [7:0] be = {overvolt_comparator_en_o, undervolt_comparator_en_o, efficiency_measure_start_o,
    slope_comp_bypass_o, current_measure_en_o, temp_sensor_en_o, efficiency_circuit_en_o, signal_chain_en_o};
  wire [3:0] bt = {high_driver_disable_o, low_driver_disable_o, bench_test_en_o, gate_drivers_disable_o};
  wire [1:0] gates = {high_gate_drive_o, low_gate_drive_o};
  analog_block_control_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .measure_done_i, .high_drive_req_i, .low_drive_req_i, .undervolt_fault_i, .overvolt_fault_i,
    .debug_pin_normal_i, .buffer_out_i, .high_gate_drive_o, .low_gate_drive_o, .fault_kill_o, .analog_debug_pin_o,
    .rectification_mode_sel_o, .high_drive_strength_sel_o, .high_dead_time_bypass_o, .low_dead_time_bypass_o,
    .neg_sense_pulldown_en_o, .pos_sense_pullup_en_o, .undervolt_accel_en_o, .overvolt_accel_en_o,
    .overvolt_comparator_en_o, .undervolt_comparator_en_o, .efficiency_measure_start_o, .slope_comp_bypass_o,
    .current_measure_en_o, .temp_sensor_en_o, .efficiency_circuit_en_o, .signal_chain_en_o,
    .gate_drivers_disable_o, .high_driver_disable_o, .low_driver_disable_o, .bench_test_en_o,
    .system_role_sel_o, .buffer_source_sel_o);
  // ==========================================
  // Helpers
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the whole request until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d}; sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      chk(32'h1, 32'h0);
      wrap_up;
    end
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h0, exp});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rdchk(4'h0, 8'h00); rdchk(4'h4, 8'h00); rdchk(4'h8, 8'h81); rdchk(4'hC, 8'h00);
    chk(bt, 4'h1);
    high_drive_req_i <= 1'b1; low_drive_req_i <= 1'b1; tick(3);
    chk(gates, 2'b00);
  endtask
  task automatic t_walk(input logic [3:0] a);
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, a, 8'h01 << i, 4'hF);
      chk(a == 4'h0 ? pe : be, 8'h01 << i);
      rdchk(a, 8'h01 << i);
    end
    wb(1'b1, a, 8'h00, 4'hE);
    chk(a == 4'h0 ? pe : be, 8'h80);
  endtask
  task automatic t_meas;
    wb(1'b1, 4'h4, 8'h20, 4'hF); chk(efficiency_measure_start_o, 1'b1);
    measure_done_i <= 1'b1; tick(1); measure_done_i <= 1'b0; tick(1);
    rdchk(4'h4, 8'h00);
  endtask
  task automatic t_bench;
    wb(1'b1, 4'h8, 8'hFF, 4'hF); rdchk(4'h8, 8'h9F);
    chk(bt, 4'hF);
    wb(1'b1, 4'h8, 8'h80, 4'hF); tick(1); chk(gates, 2'b11);
    wb(1'b1, 4'h8, 8'h88, 4'hF); tick(1); chk(gates, 2'b01);
    wb(1'b1, 4'h8, 8'h84, 4'hF); tick(1); chk(gates, 2'b10);
    debug_pin_normal_i <= 1'b0; buffer_out_i <= 1'b1;
    wb(1'b1, 4'h8, 8'h82, 4'hF); chk(analog_debug_pin_o, 1'b1);
    wb(1'b1, 4'h8, 8'h80, 4'hF); chk(analog_debug_pin_o, 1'b0);
  endtask
  task automatic t_fault;
    wb(1'b1, 4'h0, 8'h03, 4'hF);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h4, i[1] ? 8'hD0 : 8'h10, 4'hF);
      undervolt_fault_i <= !i[0]; overvolt_fault_i <= i[0]; tick(2);
      chk({fault_kill_o, gates}, i[1] ? 3'b100 : 3'b011);
      undervolt_fault_i <= 1'b0; overvolt_fault_i <= 1'b0; tick(2);
    end
    wb(1'b1, 4'h0, 8'h00, 4'hF); undervolt_fault_i <= 1'b1; tick(2);
    chk({fault_kill_o, gates}, 3'b011);
    undervolt_fault_i <= 1'b0;
  endtask
  task automatic t_mux;
    logic [4:0] srcs [3];
    srcs = '{analog_ctrl_pkg::SRC_INDUCTOR, analog_ctrl_pkg::SRC_BANDGAP, analog_ctrl_pkg::SRC_OVERCURRENT};
    for (int r = 0; r < 5; r++) for (int s = 0; s < 3; s++) begin
      wb(1'b1, 4'hC, {r[2:0], srcs[s]}, 4'hF);
      chk({system_role_sel_o, buffer_source_sel_o}, {r[2:0], srcs[s]});
    end
    wb(1'b1, 4'h2, 8'hFF, 4'hF); rdchk(4'h2, 8'h00);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    err_count = 0; checks = 0; rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
    adr_i = 4'h0; sel_i = 4'h0; dat_i = 32'h0; measure_done_i = 1'b0; high_drive_req_i = 1'b0;
    low_drive_req_i = 1'b0; undervolt_fault_i = 1'b0; overvolt_fault_i = 1'b0;
    debug_pin_normal_i = 1'b1; buffer_out_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset; t_walk(4'h0); t_walk(4'h4); t_meas; t_bench; t_fault; t_mux;
    // Mid-run reset must bring every register back, drivers off again
    rst_i <= 1'b1; tick(2); rst_i <= 1'b0;
    t_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
